// ### core/twbc_pkg.sv
// Purpose: Shared constants and types of the two-wire bus controller
// Assumes: 100 MHz ref_clk, 8-bit register port
// Notes:   Status codes keep their low three bits zero
package twbc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS      = 50;
  localparam logic [2:0] SPIKE_CYC =
    3'((SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int MAX_RATE_KHZ  = 400;
  localparam logic [14:0] HALF_BASE = 15'h0008;
  localparam int PS_SHIFT = 2;
  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFF_BIT_RATE = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h0C;
  localparam logic [7:0] OFF_CTRL     = 8'h10;
  localparam int CB_FLAG  = 7;
  localparam int CB_ACK   = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP  = 4;
  localparam int CB_EN    = 2;
  localparam int OA_GCE   = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [6:0] GC_ADDR  = 7'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Bit counter landmarks
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_ACKED = 4'h9;
  localparam logic [3:0] BIT_IDLE  = 4'hA;
  ////////////////////////////////////////////////////////////////////////////
  // Status codes
  localparam logic [7:0] ST_BUS_ERR      = 8'h00;
  localparam logic [7:0] ST_START        = 8'h08;
  localparam logic [7:0] ST_REP          = 8'h10;
  localparam logic [7:0] ST_MT_SLA_ACK   = 8'h18;
  localparam logic [7:0] ST_MT_SLA_NACK  = 8'h20;
  localparam logic [7:0] ST_MT_DATA_ACK  = 8'h28;
  localparam logic [7:0] ST_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST     = 8'h38;
  localparam logic [7:0] ST_MR_SLA_ACK   = 8'h40;
  localparam logic [7:0] ST_MR_SLA_NACK  = 8'h48;
  localparam logic [7:0] ST_MR_DATA_ACK  = 8'h50;
  localparam logic [7:0] ST_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] ST_SR_OWN_W     = 8'h60;
  localparam logic [7:0] ST_SR_GC        = 8'h70;
  localparam logic [7:0] ST_SR_DATA_ACK  = 8'h80;
  localparam logic [7:0] ST_SR_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_SR_STOP      = 8'hA0;
  localparam logic [7:0] ST_ST_OWN_R     = 8'hA8;
  localparam logic [7:0] ST_ST_DATA_ACK  = 8'hB8;
  localparam logic [7:0] ST_ST_DATA_NACK = 8'hC0;
  localparam logic [7:0] ST_NONE         = 8'hF8;
  ////////////////////////////////////////////////////////////////////////////
  // Master clock generator states
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_RS, M_STOP}
    twbc_mstate_t;
endpackage

// ### core/twbc_core.sv
// Purpose: Two-wire bus controller, master or slave, transmit or receive
// Assumes: Single 100 MHz clock; register port read data one cycle later
// Notes:   Lines are open drain; an enable low means the pin is pulled low
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Acts as master or slave, sender or receiver
// - Bus rates up to 400 kHz
// - Reject line spikes shorter than 50 ns
// - Master SCL = clk / (16 + 2*rate*4^prescale)
// - Slave timing ignores rate and prescaler
// - Shift register holds sent then received byte
// - Hidden ack bit follows control setting
// - Transmitter reports received ack in status
// - Generate and detect start, restart, stop
// - Start/stop detection works in sleep
// - Master transmitter watches arbitration continuously; the code checks it only at each SCL rise of the eight address or data bits
// - Match received address with own address
// - Optionally match general call address too
// - Own address ack depends on control
// - Address match works and wakes in sleep
// - Foreign wake during match aborts to idle
// - Flag set, status code one cycle later
// - Flag clear shows no-information status code
// - SCL held low while flag set
// - Flag after start, address, arbitration, addressed
// - Flag after data byte, slave stop/restart
// - Flag on misplaced start or stop
// - SDA changes only while SCL low
// - Seven address bits MSB first, R/W, ack
// - General call address is all zeros
// - Master waits while slave stretches SCL
module twbc_core (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Bus lines
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // System
  input  wire logic       sleep_mode,
  input  wire logic       other_wake,
  output logic            wake_req
);
  ////////////////////////////////////////////////////////////////////////////
  // Half period of the master clock
  function automatic logic [14:0] half_cycles(input logic [7:0] br,
                                              input logic [1:0] ps);
    half_cycles = twbc_pkg::HALF_BASE
                + ({7'h00, br} << (twbc_pkg::PS_SHIFT * ps));
  endfunction

  logic [7:0]  bit_rate_divider;
  logic [1:0]  rate_prescaler_field;
  logic [7:0]  own_address_register;
  logic [7:0]  byte_shift_register;
  logic [7:0]  status_code;
  logic [7:0]  code_pend;
  logic        event_flag;
  logic        ev_pulse;
  logic        ack_en;
  logic        start_cmd;
  logic        stop_cmd;
  logic        enable;
  logic        start_pend;
  logic        stop_req;
  logic        rs_req;
  logic        active;
  logic        mst;
  logic        tx;
  logic        addr_phase;
  logic        addressed;
  logic        gc_hit;
  logic        dir_rd;
  logic        arb_pend;
  logic        ack_rx;
  logic        dp_low;
  logic        bus_busy;
  logic [3:0]  bit_cnt;
  logic [1:0]  ph;
  logic [14:0] hc;
  twbc_pkg::twbc_mstate_t mst_st;
  logic [1:0]  sy1;
  logic [1:0]  sy2;
  logic [1:0]  filt;
  logic [1:0]  fprev;
  logic [2:0]  fcnt [2];

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  wire ctrl_wr  = reg_wr && (reg_addr == twbc_pkg::OFF_CTRL);
  wire dat_wr   = reg_wr && (reg_addr == twbc_pkg::OFF_DATA);
  wire go       = ctrl_wr && reg_wdata[twbc_pkg::CB_FLAG];
  wire en_now   = ctrl_wr ? reg_wdata[twbc_pkg::CB_EN] : enable;
  wire scl_f    = filt[0];
  wire sda_f    = filt[1];
  wire scl_rise = filt[0] & ~fprev[0];
  wire scl_fall = ~filt[0] & fprev[0];
  wire scl_hi   = filt[0] & fprev[0];
  // Data edges while the clock stays high are conditions, not bits
  wire start_det = scl_hi & fprev[1] & ~filt[1];
  wire stop_det  = scl_hi & ~fprev[1] & filt[1];
  wire own_cond  = (mst_st == twbc_pkg::M_START) ||
                   (mst_st == twbc_pkg::M_RS) ||
                   (mst_st == twbc_pkg::M_STOP);
  wire ext_start = start_det & ~own_cond;
  wire ext_stop  = stop_det & ~own_cond;
  wire illegal   = active && (bit_cnt > 4'h1) &&
                   (bit_cnt != twbc_pkg::BIT_IDLE);
  wire [14:0] half = half_cycles(bit_rate_divider,
                                 rate_prescaler_field);
  wire hc_done   = (hc >= half);
  wire match_own = (byte_shift_register[7:1] ==
                    own_address_register[7:1]);
  wire match_gc  = own_address_register[twbc_pkg::OA_GCE] &&
                   (byte_shift_register[7:1] ==
                    twbc_pkg::GC_ADDR);
  wire begin_tx  = mst ? (addr_phase | ~dir_rd) : dir_rd;
  wire m_scl_low = (mst_st == twbc_pkg::M_LOW) ||
                   (own_cond && mst_st != twbc_pkg::M_START &&
                    ph == 2'h0);
  wire m_sda_low = (mst_st == twbc_pkg::M_START) ||
                   (mst_st == twbc_pkg::M_LOW && addr_phase &&
                    bit_cnt == twbc_pkg::BIT_IDLE) ||
                   (mst_st == twbc_pkg::M_STOP && ph != 2'h2) ||
                   (mst_st == twbc_pkg::M_RS && ph == 2'h2);
  wire scl_low   = enable & (event_flag | m_scl_low);
  wire sda_low   = enable & (m_sda_low | dp_low);

  // Status code of a finished byte; dp_low still holds the ack we sent
  wire [7:0] done_code =
    (mst && addr_phase) ?
      (byte_shift_register[0] ?
        (ack_rx ? twbc_pkg::ST_MR_SLA_ACK : twbc_pkg::ST_MR_SLA_NACK) :
        (ack_rx ? twbc_pkg::ST_MT_SLA_ACK : twbc_pkg::ST_MT_SLA_NACK)) :
    (mst && tx) ?
      (ack_rx ? twbc_pkg::ST_MT_DATA_ACK
              : twbc_pkg::ST_MT_DATA_NACK) :
    mst ?
      (dp_low ? twbc_pkg::ST_MR_DATA_ACK : twbc_pkg::ST_MR_DATA_NACK) :
    addr_phase ?
      (dir_rd ? twbc_pkg::ST_ST_OWN_R :
        (gc_hit ? twbc_pkg::ST_SR_GC : twbc_pkg::ST_SR_OWN_W)) :
    tx ?
      (ack_rx ? twbc_pkg::ST_ST_DATA_ACK
              : twbc_pkg::ST_ST_DATA_NACK) :
      (dp_low ? twbc_pkg::ST_SR_DATA_ACK : twbc_pkg::ST_SR_DATA_NACK);

  wire [7:0] rd_mux =
    (reg_addr == twbc_pkg::OFF_BIT_RATE) ? bit_rate_divider :
    (reg_addr == twbc_pkg::OFF_STATUS)   ?
      {status_code[7:3], 1'h0, rate_prescaler_field} :
    (reg_addr == twbc_pkg::OFF_DATA)     ? byte_shift_register :
    (reg_addr == twbc_pkg::OFF_OWN_ADDR) ? own_address_register :
    (reg_addr == twbc_pkg::OFF_CTRL)     ?
      {event_flag, ack_en, start_cmd, stop_cmd, 1'h0, enable, 2'h0} :
      8'h00;

  assign scl_o    = 1'h0;
  assign sda_o    = 1'h0;
  assign scl_oe_n = ~scl_low;
  assign sda_oe_n = ~sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and spike filters
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sy1   <= 2'h3;
      sy2   <= 2'h3;
      filt  <= 2'h3;
      fprev <= 2'h3;
      for (int i = 0; i < 2; i++)
        fcnt[i] <= 3'h0;
    end
    else
    begin
      sy1   <= {sda_i, scl_i};
      sy2   <= sy1;
      fprev <= filt;
      // A level must hold a full spike time before it is believed
      for (int i = 0; i < 2; i++)
        if (sy2[i] == filt[i])
          fcnt[i] <= 3'h0;
        else if (fcnt[i] == twbc_pkg::SPIKE_CYC - 3'h1)
        begin
          filt[i] <= sy2[i];
          fcnt[i] <= 3'h0;
        end
        else
          fcnt[i] <= fcnt[i] + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-owned settings
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      bit_rate_divider     <= twbc_pkg::RST_BYTE;
      rate_prescaler_field <= 2'h0;
      own_address_register <= twbc_pkg::RST_BYTE;
      ack_en               <= 1'h0;
      start_cmd            <= 1'h0;
      enable               <= 1'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == twbc_pkg::OFF_BIT_RATE)
        bit_rate_divider <= reg_wdata;
      if (reg_addr == twbc_pkg::OFF_STATUS)
        rate_prescaler_field <= reg_wdata[1:0];
      if (reg_addr == twbc_pkg::OFF_OWN_ADDR)
        own_address_register <= reg_wdata;
      if (ctrl_wr)
      begin
        ack_en    <= reg_wdata[twbc_pkg::CB_ACK];
        start_cmd <= reg_wdata[twbc_pkg::CB_START];
        enable    <= reg_wdata[twbc_pkg::CB_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register and read port
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      status_code <= twbc_pkg::ST_NONE;
      reg_rdata   <= 8'h00;
    end
    else
    begin
      // Code lands the cycle after the flag rises
      if (ev_pulse)
        status_code <= code_pend;
      else if (!event_flag)
        status_code <= twbc_pkg::ST_NONE;
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine: master clock generator and byte engine
  always_ff @(posedge ref_clk)
  begin
    ev_pulse <= 1'h0;
    wake_req <= 1'h0;
    if (srst || !en_now)
    begin
      // Disabling drops the bus at once; software must re-arm
      event_flag <= 1'h0;
      code_pend  <= twbc_pkg::ST_NONE;
      stop_cmd   <= 1'h0;
      start_pend <= 1'h0;
      stop_req   <= 1'h0;
      rs_req     <= 1'h0;
      active     <= 1'h0;
      mst        <= 1'h0;
      tx         <= 1'h0;
      addr_phase <= 1'h0;
      addressed  <= 1'h0;
      gc_hit     <= 1'h0;
      dir_rd     <= 1'h0;
      arb_pend   <= 1'h0;
      ack_rx     <= 1'h0;
      dp_low     <= 1'h0;
      bus_busy   <= 1'h0;
      bit_cnt    <= twbc_pkg::BIT_IDLE;
      ph         <= 2'h0;
      hc         <= 15'h0000;
      mst_st     <= twbc_pkg::M_IDLE;
      if (srst)
        byte_shift_register <= twbc_pkg::RST_DATA;
      else if (dat_wr)
        byte_shift_register <= reg_wdata;
    end
    else
    begin
      if (!hc_done)
        hc <= hc + 15'h0001;
      if (dat_wr)
        byte_shift_register <= reg_wdata;
      if (ctrl_wr)
        stop_cmd <= reg_wdata[twbc_pkg::CB_STOP];
      // Writing the flag bit as one clears it and picks the next step
      if (go)
      begin
        event_flag <= 1'h0;
        if (reg_wdata[twbc_pkg::CB_STOP] && mst)
          stop_req <= 1'h1;
        else if (reg_wdata[twbc_pkg::CB_START])
        begin
          if (mst)
            rs_req <= 1'h1;
          else
            start_pend <= 1'h1;
        end
        else if (mst || addressed)
        begin
          active  <= 1'h1;
          bit_cnt <= 4'h0;
          tx      <= begin_tx;
          dp_low  <= begin_tx & ~byte_shift_register[7];
        end
      end
      if (start_pend && mst_st == twbc_pkg::M_IDLE && !bus_busy &&
          scl_f && sda_f && !event_flag)
      begin
        start_pend <= 1'h0;
        mst        <= 1'h1;
        mst_st     <= twbc_pkg::M_START;
        hc         <= 15'h0000;
      end

      case (mst_st)
        twbc_pkg::M_IDLE: ;
        twbc_pkg::M_START:
          if (hc_done && !sda_f)
          begin
            event_flag <= 1'h1;
            ev_pulse   <= 1'h1;
            code_pend  <= twbc_pkg::ST_START;
            mst_st     <= twbc_pkg::M_LOW;
            hc         <= 15'h0000;
            addr_phase <= 1'h1;
            bit_cnt    <= twbc_pkg::BIT_IDLE;
            bus_busy   <= 1'h1;
          end
        twbc_pkg::M_LOW:
          if (hc_done && !event_flag)
          begin
            hc <= 15'h0000;
            if (stop_req)
            begin
              stop_req <= 1'h0;
              ph       <= 2'h0;
              mst_st   <= twbc_pkg::M_STOP;
            end
            else if (rs_req)
            begin
              rs_req <= 1'h0;
              ph     <= 2'h0;
              mst_st <= twbc_pkg::M_RS;
            end
            else if (bit_cnt != twbc_pkg::BIT_IDLE)
              mst_st <= twbc_pkg::M_HIGH;
          end
        twbc_pkg::M_HIGH:
          if (!scl_f)
            hc <= 15'h0000;
          else if (hc_done)
          begin
            hc     <= 15'h0000;
            mst_st <= twbc_pkg::M_LOW;
          end
        twbc_pkg::M_RS,
        twbc_pkg::M_STOP:
          if (ph != 2'h2)
          begin
            if (ph == 2'h1 && !scl_f)
              hc <= 15'h0000;
            else if (hc_done)
            begin
              ph <= ph + 2'h1;
              hc <= 15'h0000;
            end
          end
          else if (hc_done && (sda_f == (mst_st == twbc_pkg::M_STOP)))
          begin
            hc <= 15'h0000;
            if (mst_st == twbc_pkg::M_STOP)
            begin
              mst_st   <= twbc_pkg::M_IDLE;
              mst      <= 1'h0;
              active   <= 1'h0;
              stop_cmd <= 1'h0;
              bus_busy <= 1'h0;
            end
            else
            begin
              event_flag <= 1'h1;
              ev_pulse   <= 1'h1;
              code_pend  <= twbc_pkg::ST_REP;
              mst_st     <= twbc_pkg::M_LOW;
              addr_phase <= 1'h1;
              bit_cnt    <= twbc_pkg::BIT_IDLE;
            end
          end
        default:
          mst_st <= twbc_pkg::M_IDLE;
      endcase

      // Byte engine follows the filtered clock in both roles
      if (active && scl_rise && bit_cnt < twbc_pkg::BIT_ACK)
      begin
        byte_shift_register <= {byte_shift_register[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
        if (mst && tx && byte_shift_register[7] && !sda_f)
        begin
          mst      <= 1'h0;
          tx       <= 1'h0;
          dp_low   <= 1'h0;
          arb_pend <= 1'h1;
          mst_st   <= twbc_pkg::M_IDLE;
        end
      end
      else if (active && scl_rise && bit_cnt == twbc_pkg::BIT_ACK)
      begin
        ack_rx  <= ~sda_f;
        bit_cnt <= twbc_pkg::BIT_ACKED;
      end
      else if (active && scl_fall && bit_cnt < twbc_pkg::BIT_ACK)
      begin
        if (arb_pend)
        begin
          // Raised while the clock is low so the hold only stretches it
          event_flag <= 1'h1;
          ev_pulse   <= 1'h1;
          code_pend  <= twbc_pkg::ST_ARB_LOST;
          arb_pend   <= 1'h0;
          active     <= 1'h0;
        end
        else
          dp_low <= tx & ~byte_shift_register[7];
      end
      else if (active && scl_fall && bit_cnt == twbc_pkg::BIT_ACK)
      begin
        if (addr_phase)
          dir_rd <= byte_shift_register[0];
        if (!mst && addr_phase)
        begin
          if ((match_own || match_gc) && ack_en)
          begin
            addressed <= 1'h1;
            gc_hit    <= ~match_own;
            dp_low    <= 1'h1;
            arb_pend  <= 1'h0;
            wake_req  <= sleep_mode;
          end
          else
          begin
            active <= 1'h0;
            dp_low <= 1'h0;
            if (arb_pend)
            begin
              event_flag <= 1'h1;
              ev_pulse   <= 1'h1;
              code_pend  <= twbc_pkg::ST_ARB_LOST;
              arb_pend   <= 1'h0;
            end
          end
        end
        else
          dp_low <= ~tx & ack_en;
      end
      else if (active && scl_fall && bit_cnt == twbc_pkg::BIT_ACKED)
      begin
        dp_low     <= 1'h0;
        bit_cnt    <= twbc_pkg::BIT_IDLE;
        addr_phase <= 1'h0;
        event_flag <= 1'h1;
        ev_pulse   <= 1'h1;
        code_pend  <= done_code;
      end

      // Conditions driven by other masters, also seen in sleep
      if (ext_start || ext_stop)
      begin
        if (illegal)
        begin
          event_flag <= 1'h1;
          ev_pulse   <= 1'h1;
          code_pend  <= twbc_pkg::ST_BUS_ERR;
          active     <= 1'h0;
          mst        <= 1'h0;
          addressed  <= 1'h0;
          dp_low     <= 1'h0;
          arb_pend   <= 1'h0;
          stop_req   <= 1'h0;
          rs_req     <= 1'h0;
          mst_st     <= twbc_pkg::M_IDLE;
        end
        else
        begin
          if (addressed)
          begin
            event_flag <= 1'h1;
            ev_pulse   <= 1'h1;
            code_pend  <= twbc_pkg::ST_SR_STOP;
          end
          addressed  <= 1'h0;
          mst        <= 1'h0;
          tx         <= 1'h0;
          active     <= ext_start;
          addr_phase <= ext_start;
          bit_cnt    <= ext_start ? 4'h0 : twbc_pkg::BIT_IDLE;
        end
        bus_busy <= ext_start;
      end

      // Another wake source during a sleeping address match aborts it
      if (sleep_mode && other_wake && !mst && addr_phase &&
          (active || addressed))
      begin
        active     <= 1'h0;
        addressed  <= 1'h0;
        addr_phase <= 1'h0;
        dp_low     <= 1'h0;
        event_flag <= 1'h0;
        wake_req   <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/twbc_core_props.sv
// Purpose: Port-level checker for the bus controller core
// Assumes: One ref_clk domain, srst synchronous active high
// Notes:   Bound to every twbc_core instance
`timescale 1ns/1ps
`default_nettype none
module twbc_core_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Bus lines
  input wire logic       scl_o,
  input wire logic       scl_oe_n,
  input wire logic       sda_o,
  input wire logic       sda_oe_n,
  // System
  input wire logic       sleep_mode,
  input wire logic       wake_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic rd_st = reg_rd && (reg_addr == twbc_pkg::OFF_STATUS);
  wire logic rd_ct = reg_rd && (reg_addr == twbc_pkg::OFF_CTRL);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_drive_low: assert property (!scl_o && !sda_o)
    else $error("pin drive value not low");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  chk_wake_sleep: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request while awake");
  chk_flag_scl: assert property (rd_ct ##1 reg_rdata[7] |-> !scl_oe_n)
    else $error("clock released while flag set");
  chk_code_scl: assert property
    (rd_st ##1 (reg_rdata[7:3] != 5'h1F) |-> !$past(scl_oe_n, 2))
    else $error("event code shown without flag");
  chk_rst_release: assert property
    ($fell(srst) |-> scl_oe_n && sda_oe_n)
    else $error("line pulled after reset");
  chk_wake_hold: assert property (wake_req |-> ##[0:200] !scl_oe_n)
    else $error("no clock hold after wake");
  cover property (wake_req);
  cover property (rd_st ##1 reg_rdata == twbc_pkg::ST_SR_OWN_W);
  cover property ($fell(scl_oe_n));
endmodule
bind twbc_core twbc_core_props u_props (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .sleep_mode(sleep_mode), .wake_req(wake_req));
`default_nettype wire

// ### verification/twbc_peer.sv
// Purpose: Far-side bus party: bit-banged master and an acking slave
// Assumes: Pull-ups on both lines, resolved by the bench
// Notes:   Slave only answers address bytes
`timescale 1ns/1ps
`default_nettype none
module twbc_peer #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter int         H    = 40
) (
  // Clock
  input  wire logic ref_clk,
  // Line levels
  input  wire logic scl,
  input  wire logic sda,
  // Pull-down enables
  output logic      scl_low,
  output logic      sda_low
);
  logic [7:0] sh = 8'h00;
  int         cnt = 9;
  logic       ack_low = 1'b0;
  logic       m_sda = 1'b0;
  logic       stuck = 1'b0;
  assign sda_low = m_sda | ack_low;
  initial scl_low = 1'b0;
  always @(negedge sda) if (scl) cnt = 0;
  always @(posedge scl)
  begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Late ack change keeps clear of a stop
  always @(negedge scl)
  begin
    repeat (3) @(posedge ref_clk);
    ack_low = (cnt == 8) && (sh[7:1] == ADDR);
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Wait out stretching or a flag hold
  task automatic rise;
    int i;
    scl_low = 1'b0;
    for (i = 0; i < 3000 && !scl; i++) @(posedge ref_clk);
    if (!scl) stuck = 1'b1;
    hold(H);
  endtask
  task automatic m_start;
    m_sda = 1'b1;
    hold(H);
    scl_low = 1'b1;
    hold(4);
  endtask
  task automatic m_byte(input logic [7:0] b, output logic ack);
    int i;
    for (i = 7; i >= 0; i--)
    begin
      m_sda = !b[i];
      hold(H);
      rise();
      scl_low = 1'b1;
      hold(4);
    end
    m_sda = 1'b0;
    hold(H);
    rise();
    ack = !sda;
    scl_low = 1'b1;
    hold(4);
  endtask
  task automatic m_stop;
    m_sda = 1'b1;
    hold(H);
    rise();
    m_sda = 1'b0;
    hold(H);
  endtask
endmodule
`default_nettype wire

// ### verification/twbc_core_tb_top.sv
// Purpose: Self-checking bench for the bus controller core
// Assumes: 100 MHz ref_clk, peer model on the two lines
// Notes:   Register rows first, then master and slave flows
`timescale 1ns/1ps
`default_nettype none
module twbc_core_tb_top;
  typedef struct packed {logic wr; logic [23:0] v;} twbc_row_t;
  logic       ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       sleep_mode = 1'b0, other_wake = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, wake_req, p_scl, p_sda, ack;
  wire logic  scl_w = scl_oe_n & !p_scl;
  wire logic  sda_w = sda_oe_n & !p_sda;
  int         error_cnt = 0, checks = 0, wakes = 0, n;
  twbc_row_t  rows [13] = '{
    '{0, 24'h00_0000}, '{0, 24'h04_00F8}, '{0, 24'h08_00FF},
    '{0, 24'h0C_0000}, '{0, 24'h10_0000}, '{0, 24'h14_0000},
    '{1, 24'h00_0200}, '{0, 24'h00_0002}, '{1, 24'h04_0300},
    '{0, 24'h04_00FB}, '{1, 24'h04_0000}, '{1, 24'h08_3C00},
    '{0, 24'h08_003C}};
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wake_req === 1'b1) wakes <= wakes + 1;
  twbc_core u_dut (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .sleep_mode(sleep_mode), .other_wake(other_wake), .wake_req(wake_req));
  twbc_peer u_peer (.ref_clk(ref_clk), .scl(scl_w), .sda(sda_w),
    .scl_low(p_scl), .sda_low(p_sda));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Bounded flag poll, then code check
  task automatic await_code(input logic [7:0] e);
    d = 8'h00;
    for (n = 0; n < 2000 && d[7] !== 1'b1; n++) rd(twbc_pkg::OFF_CTRL, d);
    if (d[7] !== 1'b1)
    begin
      error_cnt++;
      tally_and_finish();
    end
    rd(twbc_pkg::OFF_STATUS, d);
    cmp("status", e, d);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (rows[k])
      if (rows[k].wr) wr(rows[k].v[23:16], rows[k].v[15:8]);
      else
      begin
        rd(rows[k].v[23:16], d);
        cmp("reg", rows[k].v[7:0], d);
      end
    wr(twbc_pkg::OFF_CTRL, 8'hA4);
    await_code(twbc_pkg::ST_START);
    cmp("scl_held", 8'h00, {7'h00, scl_w});
    wr(twbc_pkg::OFF_DATA, 8'h54);
    wr(twbc_pkg::OFF_CTRL, 8'h84);
    await_code(twbc_pkg::ST_MT_SLA_ACK);
    wr(twbc_pkg::OFF_CTRL, 8'hA4);
    await_code(twbc_pkg::ST_REP);
    wr(twbc_pkg::OFF_DATA, 8'h22);
    wr(twbc_pkg::OFF_CTRL, 8'h84);
    await_code(twbc_pkg::ST_MT_SLA_NACK);
    wr(twbc_pkg::OFF_CTRL, 8'h94);
    d = 8'h10;
    for (n = 0; n < 500 && d[4] !== 1'b0; n++) rd(twbc_pkg::OFF_CTRL, d);
    cmp("stop", 8'h00, d & 8'h10);
    cmp("lines", 8'h03, {6'h00, scl_w, sda_w});
    rd(twbc_pkg::OFF_STATUS, d);
    cmp("idle", twbc_pkg::ST_NONE, d);
    sleep_mode <= 1'b1;
    wr(twbc_pkg::OFF_OWN_ADDR, 8'h67);
    wr(twbc_pkg::OFF_CTRL, 8'hC4);
    u_peer.m_start();
    u_peer.m_byte(8'h66, ack);
    cmp("ack", 8'h01, {7'h00, ack});
    await_code(twbc_pkg::ST_SR_OWN_W);
    cmp("wake", 8'h01, wakes[7:0]);
    wr(twbc_pkg::OFF_CTRL, 8'hC4);
    u_peer.m_byte(8'h5A, ack);
    await_code(twbc_pkg::ST_SR_DATA_ACK);
    rd(twbc_pkg::OFF_DATA, d);
    cmp("rx_byte", 8'h5A, d);
    wr(twbc_pkg::OFF_CTRL, 8'hC4);
    u_peer.m_stop();
    await_code(twbc_pkg::ST_SR_STOP);
    wr(twbc_pkg::OFF_CTRL, 8'h84);
    u_peer.m_start();
    u_peer.m_byte(8'h66, ack);
    cmp("nack", 8'h00, {7'h00, ack});
    u_peer.m_stop();
    wr(twbc_pkg::OFF_CTRL, 8'hC4);
    u_peer.m_start();
    other_wake <= 1'b1;
    @(posedge ref_clk);
    other_wake <= 1'b0;
    u_peer.m_byte(8'h66, ack);
    cmp("abort", 8'h00, {7'h00, ack});
    u_peer.m_stop();
    u_peer.m_start();
    u_peer.m_byte(8'h00, ack);
    cmp("gc_ack", 8'h01, {7'h00, ack});
    await_code(twbc_pkg::ST_SR_GC);
    cmp("stuck", 8'h00, {7'h00, u_peer.stuck});
    tally_and_finish();
  end
endmodule
`default_nettype wire
